// File: core/exec_alu.sv
`timescale 1ns/1ns
module exec_alu (
  // Operation and operands
  input  wire exec_pkg::op_t   op_in,
  input  wire logic [7:0]      acc_in,
  input  wire logic [7:0]      file_in,
  input  wire logic [7:0]      lit_in,
  input  wire logic            carry_in,
  // Result and flags
  output logic      [7:0]      res_out,
  output logic                 carry_out,
  output logic                 half_out,
  output logic                 zero_out
);
  logic [8:0] diff;
  logic [4:0] ndiff;

  // Full and low-nibble differences for the subtract
  always_comb begin
    diff  = {1'b0, file_in} - {1'b0, acc_in};
    ndiff = {1'b0, file_in[3:0]} - {1'b0, acc_in[3:0]};
  end

  // Result select; carry is a no-borrow flag on subtract
  always_comb begin
    res_out   = file_in;
    carry_out = carry_in;
    half_out  = ~ndiff[4];
    unique case (op_in)
      exec_pkg::OP_ROTL: begin
        res_out   = {file_in[6:0], carry_in};
        carry_out = file_in[7];
      end
      exec_pkg::OP_ROTR: begin
        res_out   = {carry_in, file_in[7:1]};
        carry_out = file_in[0];
      end
      exec_pkg::OP_SUB: begin
        res_out   = diff[7:0];
        carry_out = ~diff[8];
      end
      exec_pkg::OP_SWAP: res_out = {file_in[3:0], file_in[7:4]};
      exec_pkg::OP_XORL: res_out = acc_in ^ lit_in;
      exec_pkg::OP_XORF: res_out = acc_in ^ file_in;
      exec_pkg::OP_RET:  res_out = lit_in;
      default:           res_out = file_in;
    endcase
    zero_out = (res_out == 8'h00);
  end
endmodule : exec_alu

// File: core/exec_pkg.sv
package exec_pkg;
  // Overview of operation
  // - Return loads literal into accumulator, flags kept
  // - Return reloads counter from stack top, two cycles
  // - Power-down clears watchdog counter and prescaler
  // - Power-down sets expiry flag, clears powerdown flag
  // - Power-down sleeps, halts oscillator, keeps wake flag
  // - Rotate left through carry, only carry changes
  // - Rotate right through carry, only carry changes
  // - Destination bit selects accumulator or file register
  // - Subtract accumulator from file, update three flags
  // - Nibble exchange swaps halves, no flag changes
  // - Direction load accepts operand six, copies accumulator
  // - Literal XOR into accumulator, null flag only
  // - File XOR to destination, null flag only

  // Widths
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned FADDR_W = 5;
  localparam int unsigned ST_W    = 6;

  // Instruction selects presented by the fetch path
  typedef enum logic [3:0] {
    OP_NOP   = 4'h0,
    OP_RET   = 4'h1,
    OP_SLEEP = 4'h2,
    OP_ROTL  = 4'h3,
    OP_ROTR  = 4'h4,
    OP_SUB   = 4'h5,
    OP_SWAP  = 4'h6,
    OP_DIR   = 4'h7,
    OP_XORL  = 4'h8,
    OP_XORF  = 4'h9
  } op_t;

  // Sequencer states
  typedef enum logic [2:0] {
    S_RUN = 3'h1,
    S_RET = 3'h2,
    S_SLP = 3'h4
  } fsm_t;

  // Status bit positions
  localparam int unsigned ST_CARRY  = 0;
  localparam int unsigned ST_HALF   = 1;
  localparam int unsigned ST_ZERO   = 2;
  localparam int unsigned ST_PDOWN  = 3;
  localparam int unsigned ST_EXPIRY = 4;
  localparam int unsigned ST_WAKE   = 5;

  // Only legal direction-load operand
  localparam logic [4:0] DIR_PORT_SEL = 5'h06;
  // Cycles taken by a return
  localparam int unsigned RET_CYCLES  = 2;

  // APB register byte addresses
  localparam logic [7:0] ADDR_ACC    = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DIR    = 8'h08;
  localparam logic [7:0] ADDR_CTRL   = 8'h0c;
  localparam int unsigned CTRL_RUN   = 0;

  // Reset values
  localparam logic [7:0] ACC_RST    = 8'h00;
  localparam logic [5:0] STATUS_RST = 6'h18;
  localparam logic [7:0] DIR_RST    = 8'hff;
  localparam logic       RUN_RST    = 1'b1;
endpackage : exec_pkg

// File: core/instr_exec.sv
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module instr_exec #(
  parameter int unsigned PC_W = 11
) (
  // Clock, reset and freeze
  input  wire logic                CORE_CLK_IN,
  input  wire logic                RST_IN,
  input  wire logic                CE_IN,
  // Instruction issue from fetch path
  input  wire logic                INSTR_VALID_IN,
  input  wire exec_pkg::op_t       INSTR_OP_IN,
  input  wire logic [7:0]          INSTR_LIT_IN,
  input  wire logic [4:0]          INSTR_FADDR_IN,
  input  wire logic                INSTR_DEST_IN,
  output logic                     INSTR_READY_OUT,
  // File register array
  input  wire logic [7:0]          FILE_RD_DATA_IN,
  output logic                     FILE_WE_OUT,
  output logic      [4:0]          FILE_WADDR_OUT,
  output logic      [7:0]          FILE_WDATA_OUT,
  // Program counter and stack
  input  wire logic [PC_W-1:0]     STACK_TOP_IN,
  output logic                     PC_LOAD_OUT,
  output logic      [PC_W-1:0]     PC_VALUE_OUT,
  // Power and watchdog
  input  wire logic                WAKE_IN,
  output logic                     WATCHDOG_CLEAR_OUT,
  output logic                     SLEEP_OUT,
  // Core state
  output logic      [7:0]          ACC_OUT,
  output logic      [5:0]          STATUS_OUT,
  output logic      [7:0]          PIN_DIRECTION_OUT,
  // APB slave
  input  wire logic                PSEL_IN,
  input  wire logic                PENABLE_IN,
  input  wire logic                PWRITE_IN,
  input  wire logic [7:0]          PADDR_IN,
  input  wire logic [31:0]         PWDATA_IN,
  output logic      [31:0]         PRDATA_OUT,
  output logic                     PREADY_OUT,
  output logic                     PSLVERR_OUT
);

  // Whole module state in one record
  typedef struct packed {
    exec_pkg::fsm_t  fsm;
    logic [7:0]      acc;
    logic [5:0]      status;
    logic [7:0]      pin_dir;
    logic            run_en;
    logic            pc_load;
    logic [PC_W-1:0] pc_val;
    logic            wdog_clr;
    logic            fwe;
    logic [4:0]      fwaddr;
    logic [7:0]      fwdata;
    logic [31:0]     prdata;
    logic            wake_m;
    logic            wake_s;
  } core_t;

  localparam core_t CORE_RST = '{
    fsm:      exec_pkg::S_RUN,
    acc:      exec_pkg::ACC_RST,
    status:   exec_pkg::STATUS_RST,
    pin_dir:  exec_pkg::DIR_RST,
    run_en:   exec_pkg::RUN_RST,
    pc_load:  1'b0,
    pc_val:   '0,
    wdog_clr: 1'b0,
    fwe:      1'b0,
    fwaddr:   5'h00,
    fwdata:   8'h00,
    prdata:   32'h0000_0000,
    wake_m:   1'b0,
    wake_s:   1'b0
  };

  core_t      st_r;
  core_t      st_nxt;
  logic       fire;
  logic       apb_acc;
  logic       apb_wr;
  logic [7:0] alu_res;
  logic       alu_carry;
  logic       alu_half;
  logic       alu_zero;

  // Address map check, used for the error response
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == exec_pkg::ADDR_ACC) || (a == exec_pkg::ADDR_STATUS) ||
             (a == exec_pkg::ADDR_DIR) || (a == exec_pkg::ADDR_CTRL);
  endfunction : mapped

  // Read mux; narrow registers sit in the low bits
  function automatic logic [31:0] reg_read(input logic [7:0] a, input core_t s);
    reg_read = 32'h0000_0000;
    if (a == exec_pkg::ADDR_ACC) begin
      reg_read[7:0] = s.acc;
    end else if (a == exec_pkg::ADDR_STATUS) begin
      reg_read[5:0] = s.status;
    end else if (a == exec_pkg::ADDR_DIR) begin
      reg_read[7:0] = s.pin_dir;
    end else if (a == exec_pkg::ADDR_CTRL) begin
      reg_read[exec_pkg::CTRL_RUN] = s.run_en;
    end
  endfunction : reg_read

  // Arithmetic and shuffling of operands
  exec_alu u_alu (
    .op_in                 (INSTR_OP_IN),
    .acc_in                (st_r.acc),
    .file_in               (FILE_RD_DATA_IN),
    .lit_in                (INSTR_LIT_IN),
    .carry_in              (st_r.status[exec_pkg::ST_CARRY]),
    .res_out               (alu_res),
    .carry_out             (alu_carry),
    .half_out              (alu_half),
    .zero_out              (alu_zero)
  );

  // Handshakes; freeze also stalls the bus and issue
  always_comb begin
    INSTR_READY_OUT = CE_IN && st_r.run_en && (st_r.fsm == exec_pkg::S_RUN);
    fire            = INSTR_VALID_IN && INSTR_READY_OUT;
    PREADY_OUT      = CE_IN;
    apb_acc         = PSEL_IN && PENABLE_IN && CE_IN;
    apb_wr          = apb_acc && PWRITE_IN;
    PSLVERR_OUT     = PSEL_IN && PENABLE_IN && !mapped(PADDR_IN);
  end

  // Next state; software writes first so hardware updates win
  always_comb begin
    st_nxt          = st_r;
    st_nxt.pc_load  = 1'b0;
    st_nxt.wdog_clr = 1'b0;
    st_nxt.fwe      = 1'b0;
    st_nxt.wake_m   = WAKE_IN;
    st_nxt.wake_s   = st_r.wake_m;
    if (apb_wr) begin
      if (PADDR_IN == exec_pkg::ADDR_ACC) begin
        st_nxt.acc = PWDATA_IN[7:0];
      end else if (PADDR_IN == exec_pkg::ADDR_STATUS) begin
        st_nxt.status = PWDATA_IN[5:0];
      end else if (PADDR_IN == exec_pkg::ADDR_CTRL) begin
        st_nxt.run_en = PWDATA_IN[exec_pkg::CTRL_RUN];
      end
    end
    // Read data captured in setup so it is a flop in access
    if (PSEL_IN && !PENABLE_IN) begin
      st_nxt.prdata = reg_read(PADDR_IN, st_r);
    end
    unique case (st_r.fsm)
      exec_pkg::S_RUN: begin
        if (fire) begin
          unique case (INSTR_OP_IN)
            exec_pkg::OP_RET: begin
              st_nxt.acc = INSTR_LIT_IN;
              st_nxt.fsm = exec_pkg::S_RET;
            end
            exec_pkg::OP_SLEEP: begin
              st_nxt.wdog_clr = 1'b1;
              st_nxt.status[exec_pkg::ST_EXPIRY] = 1'b1;
              st_nxt.status[exec_pkg::ST_PDOWN]  = 1'b0;
              st_nxt.fsm = exec_pkg::S_SLP;
            end
            exec_pkg::OP_ROTL, exec_pkg::OP_ROTR, exec_pkg::OP_SUB,
            exec_pkg::OP_SWAP, exec_pkg::OP_XORF: begin
              // Destination select for file operations
              if (INSTR_DEST_IN) begin
                st_nxt.fwe    = 1'b1;
                st_nxt.fwaddr = INSTR_FADDR_IN;
                st_nxt.fwdata = alu_res;
              end else begin
                st_nxt.acc = alu_res;
              end
              if (INSTR_OP_IN == exec_pkg::OP_ROTL || INSTR_OP_IN == exec_pkg::OP_ROTR) begin
                st_nxt.status[exec_pkg::ST_CARRY] = alu_carry;
              end
              if (INSTR_OP_IN == exec_pkg::OP_SUB) begin
                st_nxt.status[exec_pkg::ST_CARRY] = alu_carry;
                st_nxt.status[exec_pkg::ST_HALF]  = alu_half;
                st_nxt.status[exec_pkg::ST_ZERO]  = alu_zero;
              end
              if (INSTR_OP_IN == exec_pkg::OP_XORF) begin
                st_nxt.status[exec_pkg::ST_ZERO] = alu_zero;
              end
            end
            exec_pkg::OP_DIR: begin
              // Other operands are dropped silently
              if (INSTR_FADDR_IN == exec_pkg::DIR_PORT_SEL) begin
                st_nxt.pin_dir = st_r.acc;
              end
            end
            exec_pkg::OP_XORL: begin
              st_nxt.acc = alu_res;
              st_nxt.status[exec_pkg::ST_ZERO] = alu_zero;
            end
            default: begin
            end
          endcase
        end
      end
      exec_pkg::S_RET: begin
        // Second cycle of a return: fetch restarts at stack top
        st_nxt.pc_load = 1'b1;
        st_nxt.pc_val  = STACK_TOP_IN;
        st_nxt.fsm     = exec_pkg::S_RUN;
      end
      exec_pkg::S_SLP: begin
        // Only a synchronised wake ends sleep
        if (st_r.wake_s) begin
          st_nxt.fsm = exec_pkg::S_RUN;
        end
      end
      default: st_nxt.fsm = exec_pkg::S_RUN;
    endcase
  end

  // State register, frozen while the enable is low
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      st_r <= CORE_RST;
    end else if (CE_IN) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops; sleep is decoded from the state flops
  always_comb begin
    FILE_WE_OUT        = st_r.fwe;
    FILE_WADDR_OUT     = st_r.fwaddr;
    FILE_WDATA_OUT     = st_r.fwdata;
    PC_LOAD_OUT        = st_r.pc_load;
    PC_VALUE_OUT       = st_r.pc_val;
    WATCHDOG_CLEAR_OUT = st_r.wdog_clr;
    SLEEP_OUT          = (st_r.fsm == exec_pkg::S_SLP);
    ACC_OUT            = st_r.acc;
    STATUS_OUT         = st_r.status;
    PIN_DIRECTION_OUT  = st_r.pin_dir;
    PRDATA_OUT         = st_r.prdata;
  end

  // Checks on the execution behaviour
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  // Same-cycle bus writes would overwrite what the data checks expect
  logic go_q;
  assign go_q = fire && !apb_wr;

  a_ret_literal: assert property (
    go_q && INSTR_OP_IN == exec_pkg::OP_RET |=>
      ACC_OUT == $past(INSTR_LIT_IN) && STATUS_OUT == $past(STATUS_OUT))
    else $error("return literal not in accumulator");

  a_ret_two_cycles: assert property (
    fire && INSTR_OP_IN == exec_pkg::OP_RET ##1 CE_IN |=>
      PC_LOAD_OUT && PC_VALUE_OUT == $past(STACK_TOP_IN) && !$past(INSTR_READY_OUT))
    else $error("return did not reload counter in cycle two");

  a_sleep_watchdog: assert property (
    fire && INSTR_OP_IN == exec_pkg::OP_SLEEP |=> WATCHDOG_CLEAR_OUT)
    else $error("watchdog not cleared on power-down");

  a_sleep_flags: assert property (
    fire && INSTR_OP_IN == exec_pkg::OP_SLEEP |=>
      STATUS_OUT[exec_pkg::ST_EXPIRY] && !STATUS_OUT[exec_pkg::ST_PDOWN])
    else $error("power-down flags wrong");

  a_sleep_halt: assert property (
    go_q && INSTR_OP_IN == exec_pkg::OP_SLEEP |=> SLEEP_OUT && !INSTR_READY_OUT &&
      STATUS_OUT[exec_pkg::ST_WAKE] == $past(STATUS_OUT[exec_pkg::ST_WAKE]))
    else $error("sleep not entered or wake flag changed");

  a_rot_left: assert property (
    go_q && INSTR_OP_IN == exec_pkg::OP_ROTL && !INSTR_DEST_IN |=>
      ACC_OUT == {$past(FILE_RD_DATA_IN[6:0]), $past(STATUS_OUT[exec_pkg::ST_CARRY])} &&
      STATUS_OUT[exec_pkg::ST_CARRY] == $past(FILE_RD_DATA_IN[7]))
    else $error("rotate left wrong");

  a_rot_right: assert property (
    go_q && INSTR_OP_IN == exec_pkg::OP_ROTR && !INSTR_DEST_IN |=>
      ACC_OUT == {$past(STATUS_OUT[exec_pkg::ST_CARRY]), $past(FILE_RD_DATA_IN[7:1])} &&
      STATUS_OUT[exec_pkg::ST_CARRY] == $past(FILE_RD_DATA_IN[0]))
    else $error("rotate right wrong");

  a_dest_file: assert property (
    fire && INSTR_DEST_IN && (INSTR_OP_IN == exec_pkg::OP_SWAP ||
      INSTR_OP_IN == exec_pkg::OP_XORF) |=>
      FILE_WE_OUT && FILE_WADDR_OUT == $past(INSTR_FADDR_IN))
    else $error("file destination not written");

  a_sub_carry: assert property (
    go_q && INSTR_OP_IN == exec_pkg::OP_SUB && !INSTR_DEST_IN |=>
      ACC_OUT == 8'($past(FILE_RD_DATA_IN) - $past(ACC_OUT)) &&
      STATUS_OUT[exec_pkg::ST_CARRY] == ($past(FILE_RD_DATA_IN) >= $past(ACC_OUT)))
    else $error("subtract wrong");

  a_swap_nibbles: assert property (
    go_q && INSTR_OP_IN == exec_pkg::OP_SWAP && !INSTR_DEST_IN |=>
      ACC_OUT == {$past(FILE_RD_DATA_IN[3:0]), $past(FILE_RD_DATA_IN[7:4])} &&
      STATUS_OUT == $past(STATUS_OUT))
    else $error("nibble exchange wrong");

  a_dir_load: assert property (
    fire && INSTR_OP_IN == exec_pkg::OP_DIR |=>
      PIN_DIRECTION_OUT == (($past(INSTR_FADDR_IN) == exec_pkg::DIR_PORT_SEL) ?
        $past(ACC_OUT) : $past(PIN_DIRECTION_OUT)))
    else $error("direction load wrong");

  a_xorl_zero: assert property (
    go_q && INSTR_OP_IN == exec_pkg::OP_XORL |=>
      ACC_OUT == ($past(ACC_OUT) ^ $past(INSTR_LIT_IN)) &&
      STATUS_OUT[exec_pkg::ST_ZERO] == (ACC_OUT == 8'h00))
    else $error("literal xor wrong");

  a_xorf_zero: assert property (
    go_q && INSTR_OP_IN == exec_pkg::OP_XORF && INSTR_DEST_IN |=>
      FILE_WDATA_OUT == ($past(ACC_OUT) ^ $past(FILE_RD_DATA_IN)) &&
      STATUS_OUT[exec_pkg::ST_ZERO] == (FILE_WDATA_OUT == 8'h00))
    else $error("file xor wrong");

  a_sub_flags: assert property (
    go_q && INSTR_OP_IN == exec_pkg::OP_SUB && !INSTR_DEST_IN |=>
      STATUS_OUT[exec_pkg::ST_HALF] == ($past(FILE_RD_DATA_IN[3:0]) >= $past(ACC_OUT[3:0])) &&
      STATUS_OUT[exec_pkg::ST_ZERO] == (ACC_OUT == 8'h00))
    else $error("subtract half or null flag wrong");

  a_wdog_pulse: assert property (
    WATCHDOG_CLEAR_OUT && CE_IN |=> !WATCHDOG_CLEAR_OUT)
    else $error("watchdog clear longer than one cycle");

  a_sleep_no_issue: assert property (
    SLEEP_OUT |-> !INSTR_READY_OUT)
    else $error("instruction offered while sleeping");

  c_return: cover property (fire && INSTR_OP_IN == exec_pkg::OP_RET ##2 PC_LOAD_OUT);
  c_sleep_wake: cover property (SLEEP_OUT ##[1:20] !SLEEP_OUT);
  c_sub_zero: cover property (fire && INSTR_OP_IN == exec_pkg::OP_SUB && alu_zero);
  c_apb_err: cover property (PSLVERR_OUT);
  c_dir_refused: cover property (fire && INSTR_OP_IN == exec_pkg::OP_DIR &&
    INSTR_FADDR_IN != exec_pkg::DIR_PORT_SEL);

endmodule : instr_exec

// File: testbench/file_model.sv
`timescale 1ns/1ns
module file_model #(
  parameter int unsigned         PC_W     = 11,
  parameter logic [PC_W-1:0]     RET_ADDR = 11'h5a3
) (
  // Clock
  input  wire logic              clk_in,
  // File array access
  input  wire logic [4:0]        raddr_in,
  output logic      [7:0]        rdata_out,
  input  wire logic              we_in,
  input  wire logic [4:0]        waddr_in,
  input  wire logic [7:0]        wdata_in,
  // Return address at the stack top
  output logic      [PC_W-1:0]   stack_top_out
);
  logic [7:0] mem [32];
  // Known pattern so the bench can predict every register
  initial begin
    for (int i = 0; i < 32; i++) begin
      mem[i] = 8'(i * 29 + 7);
    end
  end
  // Same-cycle read, as the core samples it at the issue edge
  assign rdata_out = mem[raddr_in];
  // Write lands at the edge that ends the pulse
  always @(posedge clk_in) begin
    if (we_in === 1'b1) begin
      mem[waddr_in] <= wdata_in;
    end
  end
  assign stack_top_out = RET_ADDR;
endmodule : file_model

// File: testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
  // Drive of the core inputs
  logic                clk, rst, ce, valid, dest, wake, psel, penable, pwrite;
  exec_pkg::op_t       op;
  logic [7:0]          lit, paddr;
  logic [4:0]          faddr;
  logic [31:0]         pwdata;
  // Core outputs
  logic                ready, fwe, pcl, wdc, slp, pready, pslverr;
  logic [4:0]          fwaddr;
  logic [7:0]          fwdata, frd, acc, pdir;
  logic [10:0]         stop, pcv;
  logic [5:0]          st;
  logic [31:0]         prdata, rd;
  // Mirrors, tables and counters
  logic [7:0]          fm [32];
  logic [7:0]          acc_e;
  logic [5:0]          st_e;
  logic                err;
  logic [7:0]          accs [4] = '{8'h00, 8'h5a, 8'hff, 8'h93};
  exec_pkg::op_t       ops [5] = '{exec_pkg::OP_ROTL, exec_pkg::OP_ROTR, exec_pkg::OP_SUB,
                                   exec_pkg::OP_SWAP, exec_pkg::OP_XORF};
  int                  errors, compares, n;
  int                  cycles = 0;

  instr_exec #(.PC_W(11)) instr_exec_inst (
    .CORE_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
    .INSTR_VALID_IN(valid), .INSTR_OP_IN(op), .INSTR_LIT_IN(lit),
    .INSTR_FADDR_IN(faddr), .INSTR_DEST_IN(dest), .INSTR_READY_OUT(ready),
    .FILE_RD_DATA_IN(frd), .FILE_WE_OUT(fwe), .FILE_WADDR_OUT(fwaddr), .FILE_WDATA_OUT(fwdata),
    .STACK_TOP_IN(stop), .PC_LOAD_OUT(pcl), .PC_VALUE_OUT(pcv),
    .WAKE_IN(wake), .WATCHDOG_CLEAR_OUT(wdc), .SLEEP_OUT(slp),
    .ACC_OUT(acc), .STATUS_OUT(st), .PIN_DIRECTION_OUT(pdir),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr)
  );

  file_model #(.PC_W(11), .RET_ADDR(11'h5a3)) file_model_inst (
    .clk_in(clk), .raddr_in(faddr), .rdata_out(frd), .we_in(fwe),
    .waddr_in(fwaddr), .wdata_in(fwdata), .stack_top_out(stop)
  );

  // Free-running clock
  always #10 clk = ~clk;

  // Hang guard, well above the fewer than two hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    if (k == 20) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
    check(err, 1'b0);
  endtask : rdchk

  // Offer one instruction; returns at the falling edge after it was taken
  task automatic issue(input exec_pkg::op_t o, input logic [7:0] l, input logic [4:0] fa,
                       input logic d);
    int k;
    k = 0;
    @(posedge clk);
    valid <= 1'b1;
    op <= o;
    lit <= l;
    faddr <= fa;
    dest <= d;
    @(negedge clk);
    while (ready !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    if (k == 20) errors++;
    @(posedge clk);
    valid <= 1'b0;
    @(negedge clk);
  endtask : issue

  // Predict, issue and compare one data instruction
  task automatic run(input exec_pkg::op_t o, input logic [7:0] l, input logic [4:0] fa,
                     input logic d);
    logic [7:0] f, r;
    logic       to_file;
    f = fm[fa];
    to_file = d;
    case (o)
      exec_pkg::OP_ROTL: begin
        r = {f[6:0], st_e[exec_pkg::ST_CARRY]};
        st_e[exec_pkg::ST_CARRY] = f[7];
      end
      exec_pkg::OP_ROTR: begin
        r = {st_e[exec_pkg::ST_CARRY], f[7:1]};
        st_e[exec_pkg::ST_CARRY] = f[0];
      end
      exec_pkg::OP_SUB: begin
        r = f - acc_e;
        st_e[exec_pkg::ST_CARRY] = (f >= acc_e);
        st_e[exec_pkg::ST_HALF] = (f[3:0] >= acc_e[3:0]);
      end
      exec_pkg::OP_SWAP: r = {f[3:0], f[7:4]};
      exec_pkg::OP_XORF: r = acc_e ^ f;
      default: begin
        r = acc_e ^ l;
        to_file = 1'b0;
      end
    endcase
    if (o inside {exec_pkg::OP_SUB, exec_pkg::OP_XORF, exec_pkg::OP_XORL}) begin
      st_e[exec_pkg::ST_ZERO] = (r == 8'h00);
    end
    issue(o, l, fa, d);
    check(fwe, to_file);
    if (to_file) begin
      check(fwaddr, fa);
      check(fwdata, r);
      fm[fa] = r;
    end else begin
      acc_e = r;
    end
    check(acc, acc_e);
    check(st, st_e);
  endtask : run

  task automatic finish_test();
    $display("Compares %0d, errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    {valid, dest, wake, psel, penable, pwrite} = 6'h00;
    op = exec_pkg::OP_NOP;
    lit = 8'h00;
    faddr = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    errors = 0;
    compares = 0;
    for (int i = 0; i < 32; i++) fm[i] = 8'(i * 29 + 7);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // Register map, reset values, refused accesses
    rdchk(exec_pkg::ADDR_ACC, 32'h00);
    rdchk(exec_pkg::ADDR_STATUS, 32'h18);
    rdchk(exec_pkg::ADDR_DIR, 32'hff);
    rdchk(exec_pkg::ADDR_CTRL, 32'h01);
    apb(1'b0, 8'h10, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, exec_pkg::ADDR_DIR, 32'h12);
    rdchk(exec_pkg::ADDR_DIR, 32'hff);
    apb(1'b1, exec_pkg::ADDR_CTRL, 32'h0);
    @(negedge clk);
    check(ready, 1'b0);
    apb(1'b1, exec_pkg::ADDR_CTRL, 32'h1);
    // Every file op, both destinations, both carry values, address 31 reached
    for (int k = 0; k < 4; k++) begin
      acc_e = accs[k];
      apb(1'b1, exec_pkg::ADDR_ACC, {24'h0, acc_e});
      st_e = 6'h18 | 6'(k & 1);
      apb(1'b1, exec_pkg::ADDR_STATUS, {26'h0, st_e});
      for (int i = 0; i < 10; i++) run(ops[i / 2], 8'h00, 5'(k * 7 + i + 1), 1'(i));
    end
    // Zero results and their clearing
    acc_e = fm[3];
    apb(1'b1, exec_pkg::ADDR_ACC, {24'h0, acc_e});
    run(exec_pkg::OP_SUB, 8'h00, 5'h03, 1'b0);
    run(exec_pkg::OP_XORL, 8'h80, 5'h00, 1'b0);
    run(exec_pkg::OP_XORL, 8'h80, 5'h00, 1'b0);
    // Direction load, legal operand then refused one
    acc_e = 8'h3c;
    apb(1'b1, exec_pkg::ADDR_ACC, 32'h3c);
    issue(exec_pkg::OP_DIR, 8'h00, 5'h06, 1'b0);
    check(pdir, 8'h3c);
    check(st, st_e);
    apb(1'b1, exec_pkg::ADDR_ACC, 32'hc3);
    issue(exec_pkg::OP_DIR, 8'h00, 5'h05, 1'b0);
    check(pdir, 8'h3c);
    rdchk(exec_pkg::ADDR_DIR, 32'h3c);
    // Return: literal now, counter reload one cycle later
    issue(exec_pkg::OP_RET, 8'hc6, 5'h00, 1'b0);
    check(acc, 8'hc6);
    check(st, st_e);
    check(ready, 1'b0);
    check(pcl, 1'b0);
    @(negedge clk);
    check(pcl, 1'b1);
    check(pcv, 11'h5a3);
    check(ready, 1'b1);
    // Freeze: no handshake answers and state held while the enable is low
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    check(ready, 1'b0);
    check(pready, 1'b0);
    check(acc, 8'hc6);
    @(posedge clk);
    ce <= 1'b1;
    // Power-down with the wake flag set beforehand
    apb(1'b1, exec_pkg::ADDR_STATUS, 32'h29);
    issue(exec_pkg::OP_SLEEP, 8'h00, 5'h00, 1'b0);
    check(wdc, 1'b1);
    check(st, 6'h31);
    check(slp, 1'b1);
    check(ready, 1'b0);
    @(negedge clk);
    check(wdc, 1'b0);
    check(slp, 1'b1);
    @(posedge clk);
    wake <= 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    check(slp, 1'b0);
    check(st, 6'h31);
    @(posedge clk);
    wake <= 1'b0;
    finish_test();
  end
endmodule : testbench
